// ### led_sink_pkg.sv
// package: constants and carrier types for the serial led sink driver
package led_sink_pkg;
    localparam int CHANNELS = 16;
    localparam int SYNC_STAGES = 2;
    localparam logic [CHANNELS-1:0] STORE_RESET = 16'h0000;
    localparam int SCLK_MAX_KHZ = 25000;
    localparam int CLOCK_KHZ = 10000;

    typedef struct packed {
        logic sclk;
        logic sdata;
        logic strobe;
        logic gate;
    } serial_in_t;

    typedef struct packed {
        logic [CHANNELS-1:0] sink_on;
        logic sdata_out;
    } sink_out_t;
endpackage

// ### pin_sync.sv
// two-flop synchroniser for a group of pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // pins
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign pin_out = sync_q;
endmodule

// ### serial_led_sink_shift_latch.sv
// serial led sink driver: shift register, storage register, output gate
`timescale 1ns/1ps
module serial_led_sink_shift_latch (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // serial link pins
    input led_sink_pkg::serial_in_t link_in,
    // sink outputs and cascade
    output led_sink_pkg::sink_out_t sink_out
);
    import led_sink_pkg::*;

    // ****************************************
    // pin synchronisation
    // ****************************************
    serial_in_t link_s;

    pin_sync #(
        .WIDTH($bits(serial_in_t))
    ) u_sync (
        .clock(clock),
        .rst(rst),
        .pin_in(link_in),
        .pin_out(link_s)
    );

    // ****************************************
    // shift and storage registers
    // ****************************************
    logic sclk_prev_q;
    logic sclk_prev_d;
    logic [CHANNELS-1:0] shift_q;
    logic [CHANNELS-1:0] shift_d;
    logic [CHANNELS-1:0] store_q;
    logic [CHANNELS-1:0] store_d;
    logic sclk_fall;

    // clock and data pass the synchroniser side by side, so the bit set
    // together with the fall is the one shifted in
    assign sclk_fall = sclk_prev_q && !link_s.sclk;

    always_comb begin
        sclk_prev_d = link_s.sclk;
        shift_d = shift_q;
        store_d = store_q;
        if (sclk_fall) begin
            shift_d = {shift_q[CHANNELS-2:0], link_s.sdata};
        end
        if (link_s.strobe) begin
            store_d = shift_q;
        end
        // strobe low: storage held
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sclk_prev_q <= 1'b0;
            shift_q <= STORE_RESET;
            store_q <= STORE_RESET;
        end else begin
            sclk_prev_q <= sclk_prev_d;
            shift_q <= shift_d;
            store_q <= store_d;
        end
    end

    // ****************************************
    // per channel sink gating
    // ****************************************
    // one sink per storage bit, dark whenever the gate is low
    logic [CHANNELS-1:0] sink_gated;

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        assign sink_gated[ch] = store_q[ch] && link_s.gate;

        a_chan_on: assert property (
            @(posedge clock) disable iff (rst)
            store_q[ch] && link_s.gate |=> sink_out.sink_on[ch])
            else $error("channel sink off with bit and gate set");

        a_chan_off: assert property (
            @(posedge clock) disable iff (rst)
            !store_q[ch] |=> !sink_out.sink_on[ch])
            else $error("channel sink on with its bit clear");
    end

    // ****************************************
    // output stage
    // ****************************************
    sink_out_t out_q;
    sink_out_t out_d;

    always_comb begin
        out_d.sdata_out = shift_q[CHANNELS-1];
        out_d.sink_on = sink_gated;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_q <= '0;
        end else begin
            out_q <= out_d;
        end
    end

    assign sink_out = out_q;

    // ****************************************
    // assertions
    // ****************************************
    sequence fall_seen;
        sclk_fall;
    endsequence

    sequence load_seen;
        link_s.strobe;
    endsequence

    sequence gate_open;
        link_s.gate;
    endsequence

    // a fall with the strobe low and the gate open
    sequence quiet_fall;
        sclk_fall && !link_s.strobe && link_s.gate;
    endsequence

    sequence quiet_open;
        !link_s.strobe && link_s.gate;
    endsequence

    sequence rise_seen;
        link_s.sclk && !sclk_prev_q;
    endsequence

    // ****************************************
    // shift register checks
    // ****************************************
    a_shift_on_fall: assert property (
        @(posedge clock) disable iff (rst)
        fall_seen |=> shift_q == {$past(shift_q[CHANNELS-2:0]),
            $past(link_s.sdata)})
        else $error("shift did not advance on falling edge");

    a_shift_hold: assert property (
        @(posedge clock) disable iff (rst)
        !sclk_fall |=> $stable(shift_q))
        else $error("shift changed without falling edge");

    a_rise_hold: assert property (
        @(posedge clock) disable iff (rst)
        rise_seen |=> $stable(shift_q))
        else $error("shift moved on a rising edge");

    a_cascade_out: assert property (
        @(posedge clock) disable iff (rst)
        1'b1 |=> sink_out.sdata_out == $past(shift_q[CHANNELS-1]))
        else $error("cascade output wrong");

    a_fall_cascade: assert property (
        @(posedge clock) disable iff (rst)
        fall_seen ##1 1'b1 |=> sink_out.sdata_out ==
            $past(shift_q[CHANNELS-2], 2))
        else $error("cascade did not advance after a fall");

    // ****************************************
    // storage register checks
    // ****************************************
    a_store_load: assert property (
        @(posedge clock) disable iff (rst)
        link_s.strobe |=> store_q == $past(shift_q))
        else $error("storage not loaded on strobe");

    a_store_hold: assert property (
        @(posedge clock) disable iff (rst)
        !link_s.strobe |=> $stable(store_q))
        else $error("storage changed with strobe low");

    a_load_to_sink: assert property (
        @(posedge clock) disable iff (rst)
        load_seen ##1 gate_open |=> sink_out.sink_on == $past(shift_q, 2))
        else $error("loaded word did not reach the sinks");

    a_quiet_shift: assert property (
        @(posedge clock) disable iff (rst)
        quiet_fall ##1 quiet_open |=> $stable(sink_out.sink_on))
        else $error("sinks moved while shifting with strobe low");

    // ****************************************
    // output gate checks
    // ****************************************
    a_sink_follow: assert property (
        @(posedge clock) disable iff (rst)
        link_s.gate |=> sink_out.sink_on == $past(store_q))
        else $error("sinks do not follow storage");

    a_gate_off: assert property (
        @(posedge clock) disable iff (rst)
        !link_s.gate |=> sink_out.sink_on == '0)
        else $error("sink on while gate low");

    a_store_gate: assert property (
        @(posedge clock) disable iff (rst)
        !link_s.gate && !link_s.strobe |=> $stable(store_q))
        else $error("gate disturbed storage");

    a_gate_keeps_shift: assert property (
        @(posedge clock) disable iff (rst)
        $changed(link_s.gate) && !sclk_fall |=> $stable(shift_q))
        else $error("gate change disturbed the shift register");
endmodule

// ### led_master_model.sv
// partner: spi style master driving the led sink pins
`timescale 1ns/1ps
module led_master_model (
    // clock
    input wire logic clock,
    // pins to the driver
    output led_sink_pkg::serial_in_t link
);
    import led_sink_pkg::*;
    initial link = '{sclk: 1'b1, sdata: 1'b0, strobe: 1'b0, gate: 1'b0};
    task automatic send_bit(input logic b);
        @(posedge clock) #1 link.sclk = 1'b0;
        link.sdata = b;
        repeat (4) @(posedge clock);
        #1 link.sclk = 1'b1;
        repeat (3) @(posedge clock);
    endtask
    task automatic load(input int pause);
        repeat (2) @(posedge clock);
        #1 link.strobe = 1'b1;
        repeat (3) @(posedge clock);
        #1 link.strobe = 1'b0;
        repeat (pause) @(posedge clock);
    endtask
    task automatic set_gate(input logic g);
        @(posedge clock) #1 link.gate = g;
        repeat (4) @(posedge clock);
    endtask
endmodule

// ### tb_serial_led_sink_shift_latch.sv
// testbench: led sink driver against a behavioural model
`timescale 1ns/1ps
module tb_serial_led_sink_shift_latch;
    import led_sink_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    serial_in_t link_in;
    sink_out_t sink_out;
    int mismatches = 0;
    int checks_done = 0;
    int seed = 32'hbcfd;
    logic [CHANNELS-1:0] m_shift = '0;
    logic [CHANNELS-1:0] m_store = '0;
    logic m_gate = 1'b0;
    logic model_bits[$];
    logic [CHANNELS-1:0] word;
    always #50 clock = ~clock;
    led_master_model master (.clock(clock), .link(link_in));
    serial_led_sink_shift_latch dut (.clock(clock), .rst(rst),
        .link_in(link_in), .sink_out(sink_out));
    task automatic check(input string what, input logic [CHANNELS-1:0] e,
                         input logic [CHANNELS-1:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask
    task automatic push(input logic b);
        logic exp_out;
        logic got_out;
        master.send_bit(b);
        #1;
        model_bits.push_back(b);
        if (model_bits.size() > CHANNELS)
            void'(model_bits.pop_front());
        exp_out = (model_bits.size() == CHANNELS) ? model_bits[0] : 1'b0;
        got_out = sink_out.sdata_out;
        m_shift = {m_shift[CHANNELS-2:0], b};
        check("cascade", CHANNELS'(exp_out), CHANNELS'(got_out));
        check("held", m_gate ? m_store : '0, sink_out.sink_on);
    endtask
    task automatic gate_to(input logic g);
        master.set_gate(g);
        m_gate = g;
        #1;
    endtask
    task automatic send_word();
        int pause;
        word = CHANNELS'($random(seed));
        pause = 4 + ($random(seed) & 32'h7);
        for (int i = CHANNELS-1; i >= 0; i--)
            push(word[i]);
        gate_to(1'b1);
        master.load(pause);
        m_store = m_shift;
        #1;
        check("stored", m_store, sink_out.sink_on);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ****************
    // main sequence
    // ****************
    initial begin
        repeat (4) @(posedge clock);
        #1 rst = 1'b0;
        for (int w = 0; w < 4; w++) begin
            send_word();
            gate_to(w[0]);
            check("gated", w[0] ? m_store : '0, sink_out.sink_on);
            $display("word %0d done", w);
        end
        // reset in mid-run: outputs and model go back to zero
        @(posedge clock) #1 rst = 1'b1;
        m_shift = '0;
        m_store = '0;
        model_bits.delete();
        #1;
        check("reset sinks", '0, sink_out.sink_on);
        check("reset cascade", '0, CHANNELS'(sink_out.sdata_out));
        repeat (2) @(posedge clock);
        #1 rst = 1'b0;
        send_word();
        $display("reset test done");
        final_report();
    end
    initial begin
        #400000;
        mismatches++;
        final_report();
    end
endmodule
